// *** fwsr_pkg.sv ***
package fwsr_pkg;
  localparam int ADDR_W = 23;
  localparam int DATA_W = 16;
  localparam int SECT_LSB = 15;

  // avalon register byte offsets
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_ADDR = 5'h04;
  localparam logic [4:0] REG_WDATA = 5'h08;
  localparam logic [4:0] REG_STATUS = 5'h0C;
  localparam logic [4:0] REG_RDATA = 5'h10;
  localparam logic [4:0] REG_SUSP = 5'h14;

  // control fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_OP_MSB = 2;
  localparam int CTRL_GO_BIT = 3;
  localparam int CTRL_PSUSP_BIT = 4;

  // status fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_RDY_BIT = 1;
  localparam int ST_RES_LSB = 2;
  localparam int ST_RES_MSB = 4;
  localparam int ST_ETMR_BIT = 8;
  localparam int ST_TLIM_BIT = 9;

  // status bit positions on the flash data bus
  localparam int DQ_POLL = 7;
  localparam int DQ_TOG1 = 6;
  localparam int DQ_TLIM = 5;
  localparam int DQ_ETMR = 3;
  localparam int DQ_TOG2 = 2;

  localparam logic [DATA_W-1:0] RST_CMD = 16'h00F0;

  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_WRITE = 3'h1;
  localparam logic [2:0] OP_POLL = 3'h2;
  localparam logic [2:0] OP_ADD = 3'h3;
  localparam logic [2:0] OP_RESET = 3'h4;

  // flash bus timing, least times rounded up to whole cycles
  localparam int CLK_PERIOD_PS = 8000;
  localparam int T_ACC_NS = 70;
  localparam int T_WP_NS = 45;
  localparam int T_REC_NS = 20;
  localparam int ACC_CYC = (T_ACC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WP_CYC = (T_WP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int REC_CYC = (T_REC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SYNC_LAT = 2;
  localparam int CNT_W = 8;

  typedef enum logic [2:0] {
    RES_NONE = 3'b000,
    RES_OK = 3'b001,
    RES_BUSY = 3'b010,
    RES_FAIL = 3'b011,
    RES_REFUSED = 3'b100,
    RES_UNSURE = 3'b101
  } fwsr_res_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_ACC = 4'b0001,
    S_RD1 = 4'b0010,
    S_RD2 = 4'b0011,
    S_RD3 = 4'b0100,
    S_RD4 = 4'b0101,
    S_POST = 4'b0110,
    S_RST = 4'b0111
  } fwsr_state_t;

  typedef enum logic [1:0] {
    P_IDLE = 2'b00,
    P_ACT = 2'b01,
    P_REC = 2'b10
  } fwsr_phase_t;
endpackage : fwsr_pkg

// *** fwsr_bus_cycle.sv ***
`timescale 1ns/10ps
module fwsr_bus_cycle (
  input wire logic clk,
  input wire logic srst,
  input wire logic start,
  input wire logic is_write,
  input wire logic [fwsr_pkg::ADDR_W-1:0] addr,
  input wire logic [fwsr_pkg::DATA_W-1:0] wdata,
  output logic done,
  output logic [fwsr_pkg::DATA_W-1:0] rdata,
  output logic [fwsr_pkg::ADDR_W-1:0] flash_addr,
  output logic [fwsr_pkg::DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe_n,
  input wire logic [fwsr_pkg::DATA_W-1:0] flash_dq_in,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n
);
  import fwsr_pkg::*;

  fwsr_phase_t phase;
  logic [CNT_W-1:0] cnt;
  logic wr;
  logic [DATA_W-1:0] dq_meta;
  logic [DATA_W-1:0] dq_sync;
  wire logic cnt_zero = (cnt == '0);
  wire logic act_end = (phase == P_ACT) && cnt_zero;
  wire logic rec_end = (phase == P_REC) && cnt_zero;
  // read strobe is held for the sync latency too, so captured data is settled
  wire logic [CNT_W-1:0] act_len = is_write ? CNT_W'(WP_CYC - 1) : CNT_W'(ACC_CYC + SYNC_LAT - 1);

  always_ff @(posedge clk) begin
    dq_meta <= flash_dq_in;
    dq_sync <= dq_meta;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      phase <= P_IDLE;
      cnt <= '0;
      wr <= 1'b0;
      done <= 1'b0;
      rdata <= '0;
      flash_addr <= '0;
      flash_dq_out <= '0;
      flash_dq_oe_n <= 1'b1;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
    end else begin
      done <= rec_end;
      unique case (phase)
        P_IDLE: begin
          if (start) begin
            phase <= P_ACT;
            cnt <= act_len;
            wr <= is_write;
            flash_addr <= addr;
            flash_dq_out <= wdata;
            flash_dq_oe_n <= ~is_write;
            flash_ce_n <= 1'b0;
            flash_oe_n <= is_write;
            flash_we_n <= ~is_write;
          end
        end
        P_ACT: begin
          cnt <= cnt - 1'b1;
          if (act_end) begin
            phase <= P_REC;
            cnt <= CNT_W'(REC_CYC - 1);
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
            if (!wr) begin
              rdata <= dq_sync;
            end
          end
        end
        P_REC: begin
          // write data held through recovery for hold time
          cnt <= cnt - 1'b1;
          if (rec_end) begin
            phase <= P_IDLE;
            flash_ce_n <= 1'b1;
            flash_dq_oe_n <= 1'b1;
          end
        end
        default: phase <= P_IDLE;
      endcase
    end
  end
endmodule : fwsr_bus_cycle

// *** fwsr_status_eval.sv ***
`timescale 1ns/10ps
module fwsr_status_eval (
  input wire logic [fwsr_pkg::DATA_W-1:0] first,
  input wire logic [fwsr_pkg::DATA_W-1:0] second,
  output logic toggle_first,
  output logic toggle_second,
  output logic timing_limit_flag,
  output logic erase_timer_flag,
  output logic data_polling_bit
);
  import fwsr_pkg::*;

  assign toggle_first = first[DQ_TOG1] ^ second[DQ_TOG1];
  assign toggle_second = first[DQ_TOG2] ^ second[DQ_TOG2];
  assign timing_limit_flag = second[DQ_TLIM];
  assign erase_timer_flag = second[DQ_ETMR];
  assign data_polling_bit = second[DQ_POLL];
endmodule : fwsr_status_eval

// *** fwsr_host.sv ***
// Operation
// - after timing-limit failure host writes reset command to return to read.
// - host confirms acceptance, checks erase-timer flag before and after each add.
// - erase-timer flag high after an add means command possibly not accepted.
// - status reads use a valid address within a selected sector.
// - status reads address the busy bank; idle banks return array data.
// - host must not read status from a program-suspended sector.
`timescale 1ns/10ps
module fwsr_host (
  input wire logic clk,
  input wire logic srst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [fwsr_pkg::ADDR_W-1:0] flash_addr,
  output logic [fwsr_pkg::DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe_n,
  input wire logic [fwsr_pkg::DATA_W-1:0] flash_dq_in,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  input wire logic ready_busy_n_output
);
  import fwsr_pkg::*;

  fwsr_state_t state;
  fwsr_state_t next_state;
  fwsr_res_t result;
  fwsr_res_t next_result;
  logic [2:0] op;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [ADDR_W-1:0] susp_addr;
  logic prog_suspended;
  logic [DATA_W-1:0] first_q;
  logic [DATA_W-1:0] next_first;
  logic [DATA_W-1:0] rdata_q;
  logic launched;
  logic ack;
  logic rdy_meta;
  logic rdy_sync;
  logic [31:0] next_readdata;
  logic cyc_done;
  logic [DATA_W-1:0] cyc_rdata;
  logic tog1;
  logic tog2;
  logic tlim;
  logic etmr;
  logic poll7;

  // avalon slave: one wait cycle on every access
  wire logic req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack;
  wire logic wr_take = avs_write & ack;
  wire logic ctrl_wr = wr_take && (avs_address == REG_CTRL);
  wire logic idle = (state == S_IDLE);
  wire logic go = ctrl_wr && avs_writedata[CTRL_GO_BIT] && idle;
  wire logic [2:0] go_op = avs_writedata[CTRL_OP_MSB:CTRL_OP_LSB];
  // a flag written together with go already applies to that go
  wire logic susp_flag = ctrl_wr ? avs_writedata[CTRL_PSUSP_BIT] : prog_suspended;
  wire logic susp_hit = susp_flag && (addr_q[ADDR_W-1:SECT_LSB] == susp_addr[ADDR_W-1:SECT_LSB]);
  wire logic in_cyc = !idle;
  wire logic cyc_start = in_cyc & ~launched;
  wire logic cyc_is_write = (state == S_RST) || ((state == S_ACC) && (op != OP_READ));
  wire logic [DATA_W-1:0] cyc_wdata = (state == S_RST) ? RST_CMD : wdata_q;
  wire logic is_poll_rd = (state == S_RD1) || (state == S_RD2) || (state == S_RD3) || (state == S_RD4)
                          || (state == S_POST);
  wire logic [31:0] status_word = 32'(
      (32'(etmr_last()) << ST_ETMR_BIT) | (32'(rdata_q[DQ_TLIM]) << ST_TLIM_BIT)
      | (32'(result) << ST_RES_LSB) | (32'(rdy_sync) << ST_RDY_BIT) | (32'(in_cyc) << ST_BUSY_BIT));
  wire logic [31:0] ctrl_word = (32'(prog_suspended) << CTRL_PSUSP_BIT) | 32'(op);

  function automatic logic etmr_last();
    etmr_last = rdata_q[DQ_ETMR];
  endfunction : etmr_last

  always_comb begin
    unique case (avs_address)
      REG_CTRL: next_readdata = ctrl_word;
      REG_ADDR: next_readdata = 32'(addr_q);
      REG_WDATA: next_readdata = 32'(wdata_q);
      REG_STATUS: next_readdata = status_word;
      REG_RDATA: next_readdata = 32'(rdata_q);
      REG_SUSP: next_readdata = 32'(susp_addr);
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  fwsr_bus_cycle u_cycle (
    .clk(clk),
    .srst(srst),
    .start(cyc_start),
    .is_write(cyc_is_write),
    .addr(addr_q),
    .wdata(cyc_wdata),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out),
    .flash_dq_oe_n(flash_dq_oe_n),
    .flash_dq_in(flash_dq_in),
    .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n)
  );

  // first_q holds the previous status read, cyc_rdata the newest
  fwsr_status_eval u_eval (
    .first(first_q),
    .second(cyc_rdata),
    .toggle_first(tog1),
    .toggle_second(tog2),
    .timing_limit_flag(tlim),
    .erase_timer_flag(etmr),
    .data_polling_bit(poll7)
  );

  always_comb begin
    next_state = state;
    next_result = result;
    next_first = first_q;
    unique case (state)
      S_IDLE: begin
        if (go) begin
          next_result = RES_NONE;
          if (go_op == OP_READ || go_op == OP_WRITE) begin
            next_state = S_ACC;
          end else if (go_op == OP_POLL || go_op == OP_ADD) begin
            if (susp_hit) begin
              next_result = RES_REFUSED;
            end else begin
              next_state = S_RD1;
            end
          end else if (go_op == OP_RESET) begin
            next_state = S_RST;
          end else begin
            next_result = RES_REFUSED;
          end
        end
      end
      S_ACC: begin
        if (cyc_done) begin
          next_state = (op == OP_ADD) ? S_POST : S_IDLE;
          next_result = RES_OK;
        end
      end
      S_RD1: begin
        if (cyc_done) begin
          next_first = cyc_rdata;
          if (op == OP_ADD) begin
            // timer already expired: erase running, the add would be ignored
            if (etmr) begin
              next_state = S_IDLE;
              next_result = RES_REFUSED;
            end else begin
              next_state = S_ACC;
            end
          end else begin
            next_state = S_RD2;
          end
        end
      end
      S_RD2: begin
        if (cyc_done) begin
          if (!tog1) begin
            next_state = S_IDLE;
            next_result = RES_OK;
          end else if (tlim) begin
            next_state = S_RD3; // toggling may stop just as the limit flag rises
          end else begin
            next_state = S_IDLE;
            next_result = RES_BUSY;
          end
        end
      end
      S_RD3: begin
        if (cyc_done) begin
          next_first = cyc_rdata;
          next_state = S_RD4;
        end
      end
      S_RD4: begin
        if (cyc_done) begin
          if (!tog1) begin
            next_state = S_IDLE;
            next_result = RES_OK;
          end else begin
            next_state = S_RST;
            next_result = RES_FAIL;
          end
        end
      end
      S_POST: begin
        if (cyc_done) begin
          next_state = S_IDLE;
          next_result = etmr ? RES_UNSURE : RES_OK;
        end
      end
      S_RST: begin
        if (cyc_done) begin
          next_state = S_IDLE;
          next_result = (result == RES_FAIL) ? RES_FAIL : RES_OK;
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    rdy_meta <= ready_busy_n_output;
    rdy_sync <= rdy_meta;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ack <= 1'b0;
      avs_readdata <= '0;
    end else begin
      ack <= req & ~ack;
      if (req & ~ack) begin
        avs_readdata <= next_readdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= S_IDLE;
      result <= RES_NONE;
      first_q <= '0;
      launched <= 1'b0;
      rdata_q <= '0;
    end else begin
      state <= next_state;
      result <= next_result;
      first_q <= next_first;
      launched <= (launched | cyc_start) & ~cyc_done;
      if (cyc_done && !cyc_is_write) begin
        rdata_q <= cyc_rdata;
      end
    end
  end

  // software registers; op and address frozen while a sequence runs
  always_ff @(posedge clk) begin
    if (srst) begin
      op <= OP_READ;
      addr_q <= '0;
      wdata_q <= '0;
      susp_addr <= '0;
      prog_suspended <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        prog_suspended <= avs_writedata[CTRL_PSUSP_BIT];
      end
      if (go) begin
        op <= go_op;
      end
      if (wr_take && idle && avs_address == REG_ADDR) begin
        addr_q <= avs_writedata[ADDR_W-1:0];
      end
      if (wr_take && idle && avs_address == REG_WDATA) begin
        wdata_q <= avs_writedata[DATA_W-1:0];
      end
      if (wr_take && avs_address == REG_SUSP) begin
        susp_addr <= avs_writedata[ADDR_W-1:0];
      end
    end
  end

  sequence fail_seen_s;
    state == S_RD4 && cyc_done && tog1;
  endsequence

  sequence reset_cmd_s;
    !flash_we_n && !flash_dq_oe_n && flash_dq_out == RST_CMD;
  endsequence

  reset_after_fail_a: assert property (@(posedge clk) disable iff (srst)
    fail_seen_s |-> ##[1:40] reset_cmd_s)
    else $error("no reset command after timing-limit failure");

  precheck_before_add_a: assert property (@(posedge clk) disable iff (srst)
    (state == S_ACC && op == OP_ADD && $changed(state)) |-> $past(state) == S_RD1)
    else $error("sector add written without prior timer check");

  postcheck_after_add_a: assert property (@(posedge clk) disable iff (srst)
    (state == S_ACC && op == OP_ADD && cyc_done) |=> state == S_POST ##[1:40] (!flash_oe_n && !flash_ce_n))
    else $error("no timer check after sector add");

  unsure_flag_a: assert property (@(posedge clk) disable iff (srst)
    (state == S_POST && cyc_done && etmr) |=> result == RES_UNSURE)
    else $error("late timer flag not reported as unsure");

  status_addr_a: assert property (@(posedge clk) disable iff (srst)
    (is_poll_rd && !flash_oe_n) |-> flash_addr == addr_q)
    else $error("status read at an address other than the chosen one");

  suspended_refuse_a: assert property (@(posedge clk) disable iff (srst)
    (go && susp_hit && (go_op == OP_POLL || go_op == OP_ADD)) |=> idle && result == RES_REFUSED [*2])
    else $error("status poll issued to program-suspended sector");

  wait_answer_a: assert property (@(posedge clk) disable iff (srst)
    (req && avs_waitrequest) |=> !avs_waitrequest)
    else $error("avalon access not answered in one wait cycle");
endmodule : fwsr_host

// *** fwsr_flash_model.sv ***
`timescale 1ns/10ps
module fwsr_flash_model #(
  parameter int ETMR_CYC = 200
) (
  input wire logic clk,
  input wire logic [2:0] mode,
  input wire logic tlim,
  input wire logic etmr_late,
  input wire logic [1:0] busy_bank,
  input wire logic [7:0] sel_sect,
  input wire logic [fwsr_pkg::DATA_W-1:0] prog_data,
  input wire logic [fwsr_pkg::ADDR_W-1:0] flash_addr,
  input wire logic [fwsr_pkg::DATA_W-1:0] dq_bus,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  output logic [fwsr_pkg::DATA_W-1:0] dev_dq,
  output logic ready_busy_n_output
);
  import fwsr_pkg::*;
  localparam logic [2:0] M_READ = 3'h0;
  localparam logic [2:0] M_PROG = 3'h1;
  localparam logic [2:0] M_ERASE = 3'h2;
  localparam logic [2:0] M_ESUSP = 3'h3;
  localparam logic [2:0] M_ESPROG = 3'h4;
  localparam logic [2:0] M_PSUSP = 3'h5;
  localparam logic [2:0] M_CERASE = 3'h6;
  logic [2:0] cur = 3'h0;
  logic [2:0] mode_q = 3'h0;
  logic tog = 1'b0;
  logic oe_q = 1'b1;
  logic we_q = 1'b1;
  logic [15:0] last = 16'h0000;
  logic [15:0] last_wr = 16'h0000;
  logic [15:0] stat;
  int etmr_cnt = 0;
  // late expiry lets the bench land an add just after the timer ran out
  wire etmr = etmr_cnt >= ETMR_CYC || etmr_late;
  wire busy = cur == M_PROG || cur == M_ERASE || cur == M_ESPROG || cur == M_CERASE;
  wire in_bank = flash_addr[ADDR_W-1:ADDR_W-2] == busy_bank;
  wire in_sel = flash_addr[ADDR_W-1:SECT_LSB] == sel_sect;
  wire drive = !flash_ce_n && !flash_oe_n;
  assign ready_busy_n_output = !busy;
  // released bus shows the inverse of the last value, never a stale copy
  assign dev_dq = drive ? stat : ~last;
  always_comb begin
    stat = flash_addr[15:0] ^ 16'h5A3C;
    if ((cur == M_PROG || cur == M_ESPROG) && in_bank) begin
      stat = 16'h0000;
      stat[DQ_POLL] = ~prog_data[DQ_POLL];
      stat[DQ_TOG1] = tog;
      stat[DQ_TLIM] = tlim;
    end else if ((cur == M_ERASE || cur == M_CERASE) && in_bank) begin
      stat = 16'h0000;
      stat[DQ_TOG1] = tog;
      stat[DQ_TLIM] = tlim;
      stat[DQ_ETMR] = etmr || cur == M_CERASE;
      stat[DQ_TOG2] = in_sel & tog;
    end else if (cur == M_ESUSP && in_sel) begin
      stat = 16'h0080;
      stat[DQ_TOG2] = tog;
    end else if (cur == M_PSUSP && in_sel) begin
      stat = {16{tog}};
    end
  end
  always @(posedge clk) begin
    oe_q <= flash_oe_n;
    we_q <= flash_we_n;
    mode_q <= mode;
    if (drive) begin
      last <= stat;
    end
    if (!oe_q && flash_oe_n) begin
      tog <= ~tog;
    end
    if (cur != M_ERASE) begin
      etmr_cnt <= 0;
    end else if (!etmr) begin
      etmr_cnt <= etmr_cnt + 1;
    end
    if (!we_q && flash_we_n) begin
      last_wr <= dq_bus;
      if (cur == M_ERASE && !etmr) begin
        etmr_cnt <= 0;
      end
      if (dq_bus == RST_CMD && !(cur == M_ERASE && etmr)) begin
        cur <= (cur == M_ESPROG) ? M_ESUSP : M_READ;
      end
    end
    if (mode != mode_q) begin
      cur <= mode;
    end
  end
endmodule : fwsr_flash_model

// *** flash_write_status_reporting_tb_top.sv ***
`timescale 1ns/10ps
module flash_write_status_reporting_tb_top;
  import fwsr_pkg::*;
  localparam logic [2:0] M_READ = 3'h0;
  localparam logic [2:0] M_PROG = 3'h1;
  localparam logic [2:0] M_ERASE = 3'h2;
  localparam logic [2:0] M_ESUSP = 3'h3;
  localparam logic [2:0] M_ESPROG = 3'h4;
  localparam logic [2:0] M_PSUSP = 3'h5;
  localparam logic [2:0] M_CERASE = 3'h6;
  logic clk, srst, avs_read, avs_write, avs_waitrequest, rb_n;
  logic flash_dq_oe_n, flash_ce_n, flash_oe_n, flash_we_n, tlim, psusp, etmr_late;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, st, rd;
  logic [ADDR_W-1:0] flash_addr;
  logic [DATA_W-1:0] flash_dq_out, dev_dq, prog_data;
  logic [2:0] mode;
  logic [1:0] busy_bank;
  logic [7:0] sel_sect;
  int n_fail = 0;
  int tests_run = 0;
  int ce_falls = 0;
  wire [DATA_W-1:0] dq_bus = !flash_dq_oe_n ? flash_dq_out : dev_dq;

  fwsr_host u_fwsr_host (.clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
    .flash_dq_oe_n(flash_dq_oe_n), .flash_dq_in(dq_bus), .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .ready_busy_n_output(rb_n));
  fwsr_flash_model #(.ETMR_CYC(200)) u_fwsr_flash_model (.clk(clk), .mode(mode), .tlim(tlim),
    .busy_bank(busy_bank), .sel_sect(sel_sect), .prog_data(prog_data), .flash_addr(flash_addr),
    .dq_bus(dq_bus), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
    .dev_dq(dev_dq), .ready_busy_n_output(rb_n), .etmr_late(etmr_late));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(negedge flash_ce_n) ce_falls++;

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_res(input logic [2:0] exp);
    chk({29'h0, st[ST_RES_MSB:ST_RES_LSB]}, {29'h0, exp});
  endtask : chk_res

  function automatic logic [31:0] arr_of(input logic [22:0] a);
    return {16'h0000, a[15:0] ^ 16'h5A3C};
  endfunction : arr_of

  // request held until waitrequest is seen low at a rising edge
  task automatic av_xfer(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    int i;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (i >= 50) begin
      n_fail++;
      summarize();
    end
    @(posedge clk);
  endtask : av_xfer

  task automatic wait_idle();
    int i;
    i = 0;
    do begin
      av_xfer(1'b0, REG_STATUS, 32'h0, st);
      i++;
    end while (st[ST_BUSY_BIT] !== 1'b0 && i < 300);
    if (i >= 300) begin
      n_fail++;
      summarize();
    end
    av_xfer(1'b0, REG_RDATA, 32'h0, rd);
  endtask : wait_idle

  task automatic run_op(input logic [2:0] op, input logic [22:0] a);
    logic [31:0] q;
    av_xfer(1'b1, REG_ADDR, {9'h000, a}, q);
    av_xfer(1'b1, REG_WDATA, 32'h0000_0030, q);
    av_xfer(1'b1, REG_CTRL, {27'h0, psusp, 1'b1, op}, q);
    wait_idle();
  endtask : run_op

  task automatic set_mode(input logic [2:0] m);
    mode <= m;
    @(posedge clk);
  endtask : set_mode

  task automatic t_read();
    logic [31:0] q;
    run_op(OP_READ, 23'h012345);
    chk(rd, arr_of(23'h012345));
    chk({31'h0, st[ST_RDY_BIT]}, 32'h1);
    av_xfer(1'b0, 5'h1C, 32'h0, q);
    chk(q, 32'h0);
  endtask : t_read

  task automatic t_prog();
    busy_bank <= 2'h1;
    prog_data <= 16'h00C3;
    set_mode(M_PROG);
    run_op(OP_POLL, 23'h200010);
    chk_res(RES_BUSY);
    chk({31'h0, st[ST_RDY_BIT]}, 32'h0);
    run_op(OP_READ, 23'h200010);
    chk({24'h0, rd[7:0] & 8'hA4}, 32'h0);
    run_op(OP_READ, 23'h600010);
    chk(rd, arr_of(23'h600010));
    set_mode(M_READ);
    run_op(OP_POLL, 23'h200010);
    chk_res(RES_OK);
  endtask : t_prog

  task automatic t_fail();
    for (int k = 0; k < 2; k++) begin
      tlim <= 1'b1;
      set_mode(k ? M_ESPROG : M_PROG);
      run_op(OP_POLL, 23'h200010);
      tlim <= 1'b0;
      chk_res(RES_FAIL);
      chk({31'h0, st[ST_TLIM_BIT]}, 32'h1);
      chk({29'h0, u_fwsr_flash_model.cur}, {29'h0, k ? M_ESUSP : M_READ});
      set_mode(M_READ);
    end
    set_mode(M_PROG);
    run_op(OP_RESET, 23'h200010);
    chk({16'h0, u_fwsr_flash_model.last_wr}, {16'h0, RST_CMD});
    chk({29'h0, u_fwsr_flash_model.cur}, {29'h0, M_READ});
    set_mode(M_READ);
  endtask : t_fail

  task automatic t_erase();
    logic [31:0] r1;
    sel_sect <= 8'h85;
    busy_bank <= 2'h2;
    set_mode(M_ERASE);
    run_op(OP_ADD, 23'h430000);
    chk_res(RES_OK);
    chk({31'h0, st[ST_ETMR_BIT]}, 32'h0);
    run_op(OP_READ, 23'h428000);
    r1 = rd;
    run_op(OP_READ, 23'h428000);
    chk((r1 ^ rd) & 32'h44, 32'h44);
    chk(rd & 32'h88, 32'h0);
    repeat (250) @(posedge clk);
    run_op(OP_READ, 23'h428000);
    chk(rd & 32'h88, 32'h08);
    run_op(OP_ADD, 23'h438000);
    chk_res(RES_REFUSED);
    chk({31'h0, st[ST_ETMR_BIT]}, 32'h1);
    run_op(OP_POLL, 23'h428000);
    chk_res(RES_BUSY);
    chk({31'h0, st[ST_RDY_BIT]}, 32'h0);
  endtask : t_erase

  task automatic t_late();
    logic [31:0] q;
    int i;
    set_mode(M_CERASE);
    run_op(OP_ADD, 23'h428000);
    chk_res(RES_REFUSED);
    chk({31'h0, st[ST_ETMR_BIT]}, 32'h1);
    set_mode(M_ERASE);
    av_xfer(1'b1, REG_CTRL, {27'h0, psusp, 1'b1, OP_ADD}, q);
    i = 0;
    while (flash_we_n !== 1'b0 && i < 100) begin
      @(posedge clk);
      i++;
    end
    if (i >= 100) begin
      n_fail++;
      summarize();
    end
    // timer runs out after the pre-check passed, before the add lands
    etmr_late <= 1'b1;
    wait_idle();
    etmr_late <= 1'b0;
    chk_res(RES_UNSURE);
    chk({31'h0, st[ST_ETMR_BIT]}, 32'h1);
  endtask : t_late

  task automatic t_esusp();
    logic [31:0] r1;
    set_mode(M_ESUSP);
    run_op(OP_READ, 23'h430010);
    chk(rd, arr_of(23'h430010));
    chk({31'h0, st[ST_RDY_BIT]}, 32'h1);
    run_op(OP_READ, 23'h428000);
    r1 = rd;
    run_op(OP_READ, 23'h428000);
    chk((r1 ^ rd) & 32'h44, 32'h04);
    run_op(OP_POLL, 23'h428000);
    chk_res(RES_OK);
  endtask : t_esusp

  task automatic t_psusp();
    logic [31:0] q;
    int n;
    set_mode(M_PSUSP);
    av_xfer(1'b1, REG_SUSP, 32'h0042_8000, q);
    psusp = 1'b1;
    n = ce_falls;
    run_op(OP_POLL, 23'h428100);
    chk_res(RES_REFUSED);
    chk(ce_falls, n);
    run_op(OP_READ, 23'h430010);
    chk(rd, arr_of(23'h430010));
    chk({31'h0, st[ST_RDY_BIT]}, 32'h1);
    psusp = 1'b0;
  endtask : t_psusp

  initial begin
    srst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    mode = M_READ;
    tlim = 1'b0;
    busy_bank = 2'h0;
    sel_sect = 8'h00;
    prog_data = 16'h0000;
    psusp = 1'b0;
    etmr_late = 1'b0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_read();
    t_prog();
    t_fail();
    t_erase();
    t_late();
    t_esusp();
    t_psusp();
    summarize();
  end

  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    summarize();
  end
endmodule : flash_write_status_reporting_tb_top
